// File: ssm_pkg.sv
// Constants for the synchronous serial receive/transmit port
// Operation
// - Either receive enable starts synchronous reception
// - Sample data on falling shift clock edge
// - Single enable receives one word, then stops
// - Continuous enable receives until software clears it
// - Both enables set behaves as continuous
// - Word done sets flag; enable gates interrupt
// - Ninth bit, errors, data readable after word
// - Clearing continuous enable clears receive error
// - Nine-bit select receives nine-bit words
// - Clearing master select enters slave mode
// - Slave mode shifts on externally supplied clock
// - Slave shifting works in any low-power mode
// - First word loads shifter at once in sleep
// - Second word waits; empty flag stays clear
// - After first word, second loads, flag sets
// - Empty event with enable wakes from sleep
// - Ninth bit field sent as ninth bit
// - Writing transmit buffer starts transmission
// - Empty flag sets on handoff, clears on write
// - Polarity select sets clock idle level
package ssm_pkg;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam int              SSM_ADDR_W       = 8;
   localparam logic [7:0]      SSM_OFS_FLAGS    = 8'h00;
   localparam logic [7:0]      SSM_OFS_ENABLES  = 8'h04;
   localparam logic [7:0]      SSM_OFS_RX_STAT  = 8'h08;
   localparam logic [7:0]      SSM_OFS_RX_DATA  = 8'h0C;
   localparam logic [7:0]      SSM_OFS_TX_STAT  = 8'h10;
   localparam logic [7:0]      SSM_OFS_BAUD_CTL = 8'h14;
   localparam logic [7:0]      SSM_OFS_DIV_HI   = 8'h18;
   localparam logic [7:0]      SSM_OFS_DIV_LO   = 8'h1C;
   localparam logic [7:0]      SSM_OFS_TX_DATA  = 8'h20;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int              SSM_B_RX_DONE    = 5;
   localparam int              SSM_B_TX_EMPTY   = 4;
   localparam int              SSM_B_RX_IE      = 5;
   localparam int              SSM_B_TX_IE      = 4;
   localparam int              SSM_B_PORT_EN    = 7;
   localparam int              SSM_B_RX_NINE    = 6;
   localparam int              SSM_B_RX_SINGLE  = 5;
   localparam int              SSM_B_RX_CONT    = 4;
   localparam int              SSM_B_RX_OVERRUN = 1;
   localparam int              SSM_B_RX_NINTH   = 0;
   localparam int              SSM_B_CLK_MASTER = 7;
   localparam int              SSM_B_TX_NINE    = 6;
   localparam int              SSM_B_TX_EN      = 5;
   localparam int              SSM_B_SYNC_MODE  = 4;
   localparam int              SSM_B_SHIFT_IDLE = 1;
   localparam int              SSM_B_TX_NINTH   = 0;
   localparam int              SSM_B_CLK_POL    = 4;
   localparam int              SSM_B_DIV16      = 3;

   // ****************************************************************
   // Reset values, counts and bus answers
   // ****************************************************************
   localparam logic            SSM_TX_EMPTY_RST = 1'b1;
   localparam logic            SSM_PIN_RELEASED = 1'b1;
   localparam logic            SSM_LINE_IDLE    = 1'b1;
   localparam logic [3:0]      SSM_BITS_EIGHT   = 4'h8;
   localparam logic [3:0]      SSM_BITS_NINE    = 4'h9;
   localparam logic [17:0]     SSM_HALF_MULT    = 18'h00002;
   localparam logic [1:0]      SSM_RESP_OKAY    = 2'h0;
   localparam logic [1:0]      SSM_RESP_SLVERR  = 2'h2;

endpackage

// File: ssm_top.sv
// Synchronous serial port: master reception and slave transmission
`timescale 1ns/1ps
module ssm_top
#(
   parameter int ADDR_W = ssm_pkg::SSM_ADDR_W
)
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   input  wire logic              sleep_mode,
   input  wire logic              shift_clock_pin_level,
   output logic                   shift_clock_pin_drive,
   output logic                   shift_clock_pin_en_n,
   input  wire logic              data_pin_level,
   output logic                   data_pin_drive,
   output logic                   data_pin_en_n,
   output logic                   periph_irq,
   output logic                   wake_req
);
   import ssm_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic              aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_have;
      logic [7:0]        w_data;
      logic              w_lane;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic              rx_done;
      logic              tx_empty;
      logic              rx_ie;
      logic              tx_ie;
      logic              port_en;
      logic              rx_nine;
      logic              rx_single;
      logic              rx_cont;
      logic              rx_overrun;
      logic              rx_ninth;
      logic [7:0]        rx_data;
      logic              clk_master;
      logic              tx_nine;
      logic              tx_en;
      logic              sync_mode;
      logic              tx_ninth;
      logic              clk_pol;
      logic              div16;
      logic [7:0]        div_hi;
      logic [7:0]        div_lo;
      logic [8:0]        rx_shift;
      logic [3:0]        rx_cnt;
      logic [17:0]       brg_cnt;
      logic              sck_lvl;
      logic [8:0]        tx_buf;
      logic              tx_buf_full;
      logic [8:0]        tx_shift;
      logic [3:0]        tx_cnt;
      logic              tx_busy;
      logic              ck_s1;
      logic              ck_s2;
      logic              ck_s3;
      logic              dt_s1;
      logic              dt_s2;
      logic              sck_en_n;
      logic              dt_drv;
      logic              dt_en_n;
      logic              irq;
      logic              wake;
   } ssm_state_type;

   ssm_state_type s_q;
   ssm_state_type s_d;
   logic          wr_tx;
   logic          wr_rx_stat;
   logic          rx_word_done;
   logic          master_rx;
   logic          slave_tx;

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb
   begin
      logic              aw_take;
      logic              w_take;
      logic              do_wr;
      logic              ck_fall;
      logic              new_lvl;
      logic [3:0]        cnt;
      logic [8:0]        sh;
      logic [3:0]        nbits_rx;
      logic [3:0]        nbits_tx;
      logic [15:0]       div;
      logic [17:0]       half;
      logic [7:0]        wd;
      aw_take      = awvalid & s_q.awready;
      w_take       = wvalid & s_q.wready;
      do_wr        = 1'b0;
      wd           = 8'h00;
      ck_fall      = s_q.ck_s3 & ~s_q.ck_s2;
      new_lvl      = 1'b0;
      cnt          = s_q.rx_cnt;
      sh           = s_q.rx_shift;
      nbits_rx     = s_q.rx_nine ? SSM_BITS_NINE : SSM_BITS_EIGHT;
      nbits_tx     = s_q.tx_nine ? SSM_BITS_NINE : SSM_BITS_EIGHT;
      div          = s_q.div16 ? {s_q.div_hi, s_q.div_lo}
                                : {8'h00, s_q.div_lo};
      half         = 18'(({2'h0, div} + 18'h00001) * SSM_HALF_MULT);
      wr_tx        = 1'b0;
      wr_rx_stat   = 1'b0;
      rx_word_done = 1'b0;
      s_d          = s_q;

      // Pin synchronisers
      s_d.ck_s1 = shift_clock_pin_level;
      s_d.ck_s2 = s_q.ck_s1;
      s_d.ck_s3 = s_q.ck_s2;
      s_d.dt_s1 = data_pin_level;
      s_d.dt_s2 = s_q.dt_s1;

      // Write address and data captured in either order
      if (aw_take)
      begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = awaddr;
      end
      if (w_take)
      begin
         s_d.w_have = 1'b1;
         s_d.w_data = wdata[7:0];
         s_d.w_lane = wstrb[0];
      end
      if (s_q.bvalid && bready)
      begin
         s_d.bvalid = 1'b0;
      end
      do_wr = s_d.aw_have & s_d.w_have & ~s_q.bvalid;
      wd    = s_d.w_data;

      // Register writes
      if (do_wr)
      begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = SSM_RESP_OKAY;
         case (8'(s_d.aw_addr))
            SSM_OFS_FLAGS, SSM_OFS_RX_DATA:
            begin
               s_d.bresp = SSM_RESP_OKAY;
            end
            SSM_OFS_ENABLES:
            begin
               if (s_d.w_lane)
               begin
                  s_d.rx_ie = wd[SSM_B_RX_IE];
                  s_d.tx_ie = wd[SSM_B_TX_IE];
               end
            end
            SSM_OFS_RX_STAT:
            begin
               if (s_d.w_lane)
               begin
                  wr_rx_stat    = 1'b1;
                  s_d.port_en   = wd[SSM_B_PORT_EN];
                  s_d.rx_nine   = wd[SSM_B_RX_NINE];
                  s_d.rx_single = wd[SSM_B_RX_SINGLE];
                  s_d.rx_cont   = wd[SSM_B_RX_CONT];
                  if (!wd[SSM_B_RX_CONT])
                  begin
                     s_d.rx_overrun = 1'b0;
                  end
               end
            end
            SSM_OFS_TX_STAT:
            begin
               if (s_d.w_lane)
               begin
                  s_d.clk_master = wd[SSM_B_CLK_MASTER];
                  s_d.tx_nine    = wd[SSM_B_TX_NINE];
                  s_d.tx_en      = wd[SSM_B_TX_EN];
                  s_d.sync_mode  = wd[SSM_B_SYNC_MODE];
                  s_d.tx_ninth   = wd[SSM_B_TX_NINTH];
               end
            end
            SSM_OFS_BAUD_CTL:
            begin
               if (s_d.w_lane)
               begin
                  s_d.clk_pol = wd[SSM_B_CLK_POL];
                  s_d.div16   = wd[SSM_B_DIV16];
               end
            end
            SSM_OFS_DIV_HI:
            begin
               if (s_d.w_lane)
               begin
                  s_d.div_hi = wd;
               end
            end
            SSM_OFS_DIV_LO:
            begin
               if (s_d.w_lane)
               begin
                  s_d.div_lo = wd;
               end
            end
            SSM_OFS_TX_DATA:
            begin
               if (s_d.w_lane)
               begin
                  wr_tx           = 1'b1;
                  s_d.tx_buf      = {s_q.tx_ninth, wd};
                  s_d.tx_buf_full = 1'b1;
                  s_d.tx_empty    = 1'b0;
               end
            end
            default:
            begin
               s_d.bresp = SSM_RESP_SLVERR;
            end
         endcase
      end

      // Register reads
      if (s_q.rvalid && rready)
      begin
         s_d.rvalid = 1'b0;
      end
      if (arvalid && s_q.arready)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = SSM_RESP_OKAY;
         s_d.rdata  = '0;
         case (8'(araddr))
            SSM_OFS_FLAGS:
            begin
               s_d.rdata[SSM_B_RX_DONE]  = s_q.rx_done;
               s_d.rdata[SSM_B_TX_EMPTY] = s_q.tx_empty;
            end
            SSM_OFS_ENABLES:
            begin
               s_d.rdata[SSM_B_RX_IE] = s_q.rx_ie;
               s_d.rdata[SSM_B_TX_IE] = s_q.tx_ie;
            end
            SSM_OFS_RX_STAT:
            begin
               s_d.rdata[SSM_B_PORT_EN]    = s_q.port_en;
               s_d.rdata[SSM_B_RX_NINE]    = s_q.rx_nine;
               s_d.rdata[SSM_B_RX_SINGLE]  = s_q.rx_single;
               s_d.rdata[SSM_B_RX_CONT]    = s_q.rx_cont;
               s_d.rdata[SSM_B_RX_OVERRUN] = s_q.rx_overrun;
               s_d.rdata[SSM_B_RX_NINTH]   = s_q.rx_ninth;
            end
            SSM_OFS_RX_DATA:
            begin
               s_d.rdata[7:0] = s_q.rx_data;
               s_d.rx_done    = 1'b0;
            end
            SSM_OFS_TX_STAT:
            begin
               s_d.rdata[SSM_B_CLK_MASTER] = s_q.clk_master;
               s_d.rdata[SSM_B_TX_NINE]    = s_q.tx_nine;
               s_d.rdata[SSM_B_TX_EN]      = s_q.tx_en;
               s_d.rdata[SSM_B_SYNC_MODE]  = s_q.sync_mode;
               s_d.rdata[SSM_B_SHIFT_IDLE] = ~s_q.tx_busy;
               s_d.rdata[SSM_B_TX_NINTH]   = s_q.tx_ninth;
            end
            SSM_OFS_BAUD_CTL:
            begin
               s_d.rdata[SSM_B_CLK_POL] = s_q.clk_pol;
               s_d.rdata[SSM_B_DIV16]   = s_q.div16;
            end
            SSM_OFS_DIV_HI:
            begin
               s_d.rdata[7:0] = s_q.div_hi;
            end
            SSM_OFS_DIV_LO:
            begin
               s_d.rdata[7:0] = s_q.div_lo;
            end
            SSM_OFS_TX_DATA:
            begin
               s_d.rdata[7:0] = s_q.tx_buf[7:0];
            end
            default:
            begin
               s_d.rresp = SSM_RESP_SLVERR;
            end
         endcase
      end

      // Master reception: clock generator and sampler
      master_rx = s_q.sync_mode & s_q.port_en & s_q.clk_master
                & (s_q.rx_single | s_q.rx_cont);
      if (!master_rx)
      begin
         s_d.sck_lvl = s_d.clk_pol;
         s_d.brg_cnt = half - 18'h00001;
         s_d.rx_cnt  = 4'h0;
      end
      else if (s_q.brg_cnt != 18'h00000)
      begin
         s_d.brg_cnt = s_q.brg_cnt - 18'h00001;
      end
      else
      begin
         s_d.brg_cnt = half - 18'h00001;
         new_lvl     = ~s_q.sck_lvl;
         s_d.sck_lvl = new_lvl;
         if (!new_lvl)
         begin
            sh  = {s_q.dt_s2, s_q.rx_shift[8:1]};
            cnt = s_q.rx_cnt + 4'h1;
         end
         if (new_lvl == s_q.clk_pol && cnt == nbits_rx)
         begin
            rx_word_done = 1'b1;
            cnt          = 4'h0;
            if (!s_q.rx_cont)
            begin
               s_d.rx_single = 1'b0;
            end
            if (s_d.rx_done)
            begin
               // A clear of continuous mode in this cycle wins
               if (!wr_rx_stat || s_d.rx_cont)
               begin
                  s_d.rx_overrun = 1'b1;
               end
            end
            else
            begin
               s_d.rx_done  = 1'b1;
               s_d.rx_data  = s_q.rx_nine ? sh[7:0] : sh[8:1];
               s_d.rx_ninth = s_q.rx_nine & sh[8];
            end
         end
         s_d.rx_shift = sh;
         s_d.rx_cnt   = cnt;
      end

      // Slave transmission on the external shift clock
      slave_tx = s_q.sync_mode & s_q.port_en & ~s_q.clk_master
               & s_q.tx_en;
      if (!slave_tx)
      begin
         s_d.tx_busy = 1'b0;
         s_d.tx_cnt  = 4'h0;
      end
      else
      begin
         if (s_q.tx_busy && ck_fall)
         begin
            s_d.tx_shift = {1'b0, s_q.tx_shift[8:1]};
            s_d.tx_cnt   = s_q.tx_cnt + 4'h1;
            if (s_q.tx_cnt + 4'h1 == nbits_tx)
            begin
               s_d.tx_busy = 1'b0;
            end
         end
         if (!s_d.tx_busy && s_q.tx_buf_full && !wr_tx)
         begin
            s_d.tx_shift    = s_q.tx_buf;
            s_d.tx_busy     = 1'b1;
            s_d.tx_cnt      = 4'h0;
            s_d.tx_buf_full = 1'b0;
            s_d.tx_empty    = 1'b1;
         end
      end

      // Pin and request outputs
      s_d.sck_en_n = ~(s_d.sync_mode & s_d.port_en & s_d.clk_master);
      s_d.dt_en_n  = ~(s_d.sync_mode & s_d.port_en & ~s_d.clk_master
                       & s_d.tx_en);
      s_d.dt_drv   = s_d.tx_busy ? s_d.tx_shift[0] : SSM_LINE_IDLE;
      s_d.irq      = (s_d.rx_done & s_d.rx_ie)
                   | (s_d.tx_empty & s_d.tx_ie);
      s_d.wake     = sleep_mode & s_d.irq;

      // Bus ready flags
      s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
      s_d.wready  = ~s_d.w_have & ~s_d.bvalid;
      s_d.arready = ~s_d.rvalid;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q          <= '0;
         s_q.tx_empty <= SSM_TX_EMPTY_RST;
         s_q.sck_en_n <= SSM_PIN_RELEASED;
         s_q.dt_en_n  <= SSM_PIN_RELEASED;
         s_q.dt_drv   <= SSM_LINE_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign awready               = s_q.awready;
   assign wready                = s_q.wready;
   assign bvalid                = s_q.bvalid;
   assign bresp                 = s_q.bresp;
   assign arready               = s_q.arready;
   assign rvalid                = s_q.rvalid;
   assign rdata                 = s_q.rdata;
   assign rresp                 = s_q.rresp;
   assign shift_clock_pin_drive = s_q.sck_lvl;
   assign shift_clock_pin_en_n  = s_q.sck_en_n;
   assign data_pin_drive        = s_q.dt_drv;
   assign data_pin_en_n         = s_q.dt_en_n;
   assign periph_irq            = s_q.irq;
   assign wake_req              = s_q.wake;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking ssm_cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_IDLE_NO_RX: assert property (
      !master_rx |=> s_q.rx_cnt == 4'h0)
      else $error("bit count moved without reception enabled");
   AST_SAMPLE_FALL: assert property (
      master_rx && s_d.rx_cnt != s_q.rx_cnt && s_d.rx_cnt != 4'h0
      |=> $fell(shift_clock_pin_drive))
      else $error("bit sampled off the falling clock edge");
   AST_SINGLE_STOP: assert property (
      rx_word_done && !s_q.rx_cont |=> !s_q.rx_single ##1 !master_rx)
      else $error("single reception did not stop");
   AST_CONT_KEEP: assert property (
      rx_word_done && s_q.rx_cont && !wr_rx_stat |=> master_rx)
      else $error("continuous reception stopped by itself");
   AST_IRQ_RX: assert property (
      s_q.rx_done && s_q.rx_ie |-> periph_irq || $rose(s_q.rx_done)
                                   || $rose(s_q.rx_ie))
      else $error("receive request missing");
   AST_ERR_CLR: assert property (
      wr_rx_stat && !s_d.rx_cont |=> !s_q.rx_overrun)
      else $error("receive error not cleared");
   AST_IDLE_LVL: assert property (
      !master_rx [*2] |-> shift_clock_pin_drive == s_q.clk_pol)
      else $error("shift clock not at idle level");
   AST_SLAVE_REL: assert property (
      s_q.sync_mode && !s_q.clk_master |=> shift_clock_pin_en_n)
      else $error("clock pin driven in slave mode");
   AST_HOLD_EMPTY: assert property (
      s_q.tx_buf_full |-> !s_q.tx_empty)
      else $error("empty flag set while buffer holds a word");
   AST_LOAD_FLAG: assert property (
      $rose(s_q.tx_busy) |-> s_q.tx_empty && !s_q.tx_buf_full
                             && s_q.tx_cnt == 4'h0)
      else $error("handoff did not set empty flag");
   AST_WAKE: assert property (
      sleep_mode && s_q.tx_empty && s_q.tx_ie |=> ##1 wake_req)
      else $error("no wake on empty event");

   COV_RX_WORD: cover property (rx_word_done && !s_q.rx_cont);
   COV_RX_TWO: cover property (
      rx_word_done && s_q.rx_cont ##[1:1000] rx_word_done);
   COV_TX_SLEEP: cover property (
      sleep_mode && s_q.tx_busy && s_q.tx_buf_full ##[1:1000] wake_req);

endmodule

// File: ssm_peer.sv
// Far-side serial device: data source and slave clock
`timescale 1ns/1ps
module ssm_peer
(
   input  wire logic       ck_drive,
   input  wire logic       ck_en_n,
   input  wire logic       dt_drive,
   input  wire logic       dt_en_n,
   input  wire logic [8:0] word,
   input  wire logic [3:0] nb,
   input  wire logic       start,
   output logic            ck_level,
   output logic            dt_level
);
   logic       pck = 1'h1;
   int         idx = 0;
   logic [8:0] got;
   // Pin levels from the design's enables; the peer drives whenever the design releases
   assign ck_level = ck_en_n ? pck : ck_drive;
   assign dt_level = dt_en_n ? word[idx % nb] : dt_drive;
   // Next bit after each falling clock edge
   always @(negedge ck_level or posedge start)
      idx <= start ? 0 : idx + 1;
   // Outside clock, stands still between frames
   task automatic frame(input int n);
      got = 9'h000;
      for (int k = 0; k < n; k++)
      begin
         got[k] = dt_level;
         #40 pck = 1'h0;
         #40 pck = 1'h1;
      end
   endtask
endmodule

// File: ssm_top_tb.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module ssm_top_tb;
   import ssm_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready;
   logic        arvalid, rready, sleep_mode, start, hi;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        ckd, cke, dtd, dte, ckl, dtl, irq, wake;
   logic [1:0]  bresp, rresp, r;
   logic [3:0]  nb;
   logic [7:0]  awaddr, araddr, d;
   logic [8:0]  word;
   logic [31:0] wdata, rdata;
   int          n_fail, checks_done;
   // Design and far side
   ssm_top ssm_top_i
   (
      .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
      .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
      .rdata, .rresp, .sleep_mode, .shift_clock_pin_level(ckl),
      .shift_clock_pin_drive(ckd), .shift_clock_pin_en_n(cke),
      .data_pin_level(dtl), .data_pin_drive(dtd), .data_pin_en_n(dte),
      .periph_irq(irq), .wake_req(wake)
   );
   ssm_peer ssm_peer_i
   (
      .ck_drive(ckd), .ck_en_n(cke), .dt_drive(dtd), .dt_en_n(dte),
      .word, .nb, .start, .ck_level(ckl), .dt_level(dtl)
   );
   // Verdict and end of run
   task automatic end_sim;
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard
   task automatic lim(input int i, input int n);
      if (i >= n)
      begin
         n_fail++;
         end_sim;
      end
   endtask
   task automatic chk(input string n, input logic [8:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         $display("[ERR] %s exp %h got %h", n, e, g);
         n_fail++;
      end
   endtask
   // Bus write: address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int i;
      awaddr <= a;
      wdata <= {24'h000000, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
         if (bvalid)
            break;
      end
      r = bresp;
      bready <= 1'h0;
      lim(i, 50);
      repeat (2) @(posedge aclk);
   endtask
   // Bus read into d and r
   task automatic rd(input logic [7:0] a);
      int i;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'h0;
         if (rvalid)
            break;
      end
      d = rdata[7:0];
      r = rresp;
      rready <= 1'h0;
      lim(i, 50);
      @(posedge aclk);
   endtask
   // Poll a register until a masked bit shows
   task automatic wt(input logic [7:0] a, input logic [7:0] m);
      int i;
      for (i = 0; i < 400; i++)
      begin
         rd(a);
         if ((d & m) != 8'h00)
            break;
      end
      lim(i, 400);
   endtask
   task automatic restart(input logic [3:0] n);
      nb <= n;
      start <= 1'h1;
      @(posedge aclk);
      start <= 1'h0;
   endtask
   initial
   begin
      aclk = 1'h0;
      forever #2 aclk = ~aclk;
   end
   // Main sequence
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {sleep_mode, start, hi, awaddr, araddr, wdata} = '0;
      word = 9'h1B3;
      nb = 4'h8;
      n_fail = 0;
      checks_done = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(SSM_OFS_FLAGS); chk("flags", 9'h010, d);
      rd(SSM_OFS_RX_STAT); chk("rxstat", 9'h000, d);
      rd(8'h40); chk("rresp", 9'h002, r);
      wr(SSM_OFS_DIV_LO, 8'h03);
      wr(SSM_OFS_TX_STAT, 8'h90);
      wr(8'h40, 8'h00); chk("bresp", 9'h002, r);
      wr(SSM_OFS_RX_STAT, 8'h80);
      chk("bresp", 9'h000, r);
      chk("cken", 9'h000, cke);
      wr(SSM_OFS_BAUD_CTL, 8'h10);
      chk("ckidle", 9'h001, ckd);
      wr(SSM_OFS_BAUD_CTL, 8'h00);
      chk("ckidle", 9'h000, ckd);
      restart(4'h8);
      wr(SSM_OFS_RX_STAT, 8'hA0);
      wt(SSM_OFS_FLAGS, 8'h20);
      chk("irq", 9'h000, irq);
      repeat (40) @(posedge aclk) hi |= ckd;
      chk("ckstop", 9'h000, hi);
      rd(SSM_OFS_RX_STAT); chk("rxstat", 9'h080, d);
      wr(SSM_OFS_ENABLES, 8'h20);
      chk("irq", 9'h001, irq);
      rd(SSM_OFS_RX_DATA); chk("rxdata", 9'h0B3, d);
      restart(4'h9);
      wr(SSM_OFS_RX_STAT, 8'hF0);
      wt(SSM_OFS_FLAGS, 8'h20);
      rd(SSM_OFS_RX_STAT); chk("ninth", 9'h0F1, d);
      rd(SSM_OFS_RX_DATA); chk("rxdata", 9'h0B3, d);
      wt(SSM_OFS_RX_STAT, 8'h02);
      wr(SSM_OFS_RX_STAT, 8'h80);
      rd(SSM_OFS_RX_STAT); chk("ovr", 9'h000, d & 8'h02);
      rd(SSM_OFS_RX_DATA);
      wr(SSM_OFS_ENABLES, 8'h10);
      wr(SSM_OFS_TX_STAT, 8'h71);
      chk("cken", 9'h001, cke);
      chk("dten", 9'h000, dte);
      wr(SSM_OFS_TX_DATA, 8'h3C);
      wr(SSM_OFS_TX_DATA, 8'hC3);
      sleep_mode <= 1'h1;
      rd(SSM_OFS_FLAGS); chk("txe", 9'h000, d);
      chk("wake", 9'h000, wake);
      ssm_peer_i.frame(9);
      chk("tx1", 9'h13C, ssm_peer_i.got);
      repeat (4) @(posedge aclk);
      rd(SSM_OFS_FLAGS); chk("txe", 9'h010, d);
      chk("wake", 9'h001, wake);
      ssm_peer_i.frame(9);
      chk("tx2", 9'h1C3, ssm_peer_i.got);
      end_sim;
   end
endmodule
